// >>> hw/swe_consts.svh
// constants for the serial eeprom programming path
`ifndef SWE_CONSTS_SVH
`define SWE_CONSTS_SVH

// core clock period and link timing, in ns
`define SWE_CLK_NS 50
`define SWE_TCSL_NS 250
`define SWE_TCSL_CYCLES ((`SWE_TCSL_NS + `SWE_CLK_NS - 1) / `SWE_CLK_NS)

// self-timed cycle durations, in ns
`define SWE_WRITE_NS 4000000
`define SWE_FILL_NS 16000000
`define SWE_FILL_MAX_NS 30000000

// pin order inside the synchroniser vector
`define SWE_PIN_CS 0
`define SWE_PIN_SCLK 1
`define SWE_PIN_DI 2
`define SWE_PIN_WIDE 3
`define SWE_PIN_COUNT 4

// frame lengths in bits after the start bit
`define SWE_HDR_X16 5'h08
`define SWE_HDR_X8 5'h09
`define SWE_TOTAL_X16 5'h18
`define SWE_TOTAL_X8 5'h11

// opcodes and the two address bits that extend opcode 00
`define SWE_OP_WRITE 2'h1
`define SWE_OP_EXT 2'h0
`define SWE_EXT_FILL 2'h1
`define SWE_EXT_ENABLE 2'h3
`define SWE_EXT_DISABLE 2'h0

// array geometry in bytes
`define SWE_MEM_BYTES 128
`define SWE_LAST_BYTE 7'h7f
`define SWE_ERASED 8'hff

`endif

// >>> hw/swe_pkg.sv
// types shared by the serial eeprom programming path
package swe_pkg;

   typedef enum logic [6:0] {
      SWE_IDLE  = 7'h01,
      SWE_SHIFT = 7'h02,
      SWE_ARMED = 7'h04,
      SWE_SKIP  = 7'h08,
      SWE_ERASE = 7'h10,
      SWE_WAIT  = 7'h20,
      SWE_PROG  = 7'h40
   } swe_state_e;

endpackage

// >>> hw/swe_pin_if.sv
// filtered pin levels passed from the synchroniser to the core
`timescale 1ns/10ps
interface swe_pin_if;
   logic cs;
   logic sclk;
   logic di;
   logic wide;
   modport sync_mp (output cs, output sclk, output di, output wide);
   modport core_mp (input cs, input sclk, input di, input wide);
endinterface

// >>> hw/swe_pin_sync.sv
// three-flop synchroniser with agreement filter for the serial pins
`timescale 1ns/10ps
`include "swe_consts.svh"
module swe_pin_sync (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [`SWE_PIN_COUNT-1:0] pin_in,
   swe_pin_if.sync_mp pins
);
   logic [`SWE_PIN_COUNT-1:0] s1_ff;
   logic [`SWE_PIN_COUNT-1:0] s2_ff;
   logic [`SWE_PIN_COUNT-1:0] s3_ff;
   logic [`SWE_PIN_COUNT-1:0] lvl_ff;
   logic [`SWE_PIN_COUNT-1:0] nxt_lvl;

   // a level moves only once stages two and three agree
   always_comb begin
      nxt_lvl = ((s2_ff ~^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & lvl_ff);
   end

   // s1 feeds s2 alone, so metastability never reaches the filter
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         lvl_ff <= '0;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         lvl_ff <= nxt_lvl;
      end
   end

   // filtered levels out to the core
   assign pins.cs = lvl_ff[`SWE_PIN_CS];
   assign pins.sclk = lvl_ff[`SWE_PIN_SCLK];
   assign pins.di = lvl_ff[`SWE_PIN_DI];
   assign pins.wide = lvl_ff[`SWE_PIN_WIDE];
endmodule

// >>> hw/swe_core.sv
// serial eeprom write and fill-all programming path
//
// Contract
// - write shifts 8 or 16 data bits, stores
// - select fall starts erase then program cycle
// - select high after 250 ns shows status
// - status low while cycle still runs
// - status high when done, new instruction accepted
// - word write timer, configurable, 4 ms
// - fill writes every location with one value
// - fill self-timed from select fall, no clocks
// - fill erases whole array first
// - fill only while programming enabled
// - fill takes 16 ms, at most 30
// - start bit at first rise with select, input high
// - sample input bits on serial clock rise
// - programming disabled after power-up until enable
// - output released on every select fall
`timescale 1ns/10ps
`include "swe_consts.svh"
module swe_core #(
   parameter logic [19:0] WRITE_CYCLES = 20'(`SWE_WRITE_NS / `SWE_CLK_NS),
   parameter logic [19:0] FILL_CYCLES = 20'(`SWE_FILL_NS / `SWE_CLK_NS)
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic dev_select_pin,
   input wire logic serial_clk_pin,
   input wire logic serial_in_pin,
   input wire logic word_width_select,
   output logic serial_out_pin_o,
   output logic serial_out_pin_oe
);
   localparam logic [2:0] TCSL_CYCLES = 3'(`SWE_TCSL_CYCLES);

   swe_pin_if pins ();

   swe_pin_sync u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin_in({word_width_select, serial_in_pin, serial_clk_pin, dev_select_pin}),
      .pins(pins.sync_mp)
   );

   swe_pkg::swe_state_e state_ff, nxt_state;
   logic cs_d_ff, ck_d_ff;
   logic [4:0] cnt_ff, nxt_cnt;
   logic [23:0] sreg_ff, nxt_sreg;
   logic [6:0] addr_ff, nxt_addr;
   logic [15:0] data_ff, nxt_data;
   logic fill_ff, nxt_fill;
   logic wide_ff, nxt_wide;
   logic en_ff, nxt_en;
   logic [6:0] idx_ff, nxt_idx;
   logic [6:0] first_ff, nxt_first;
   logic [6:0] last_ff, nxt_last;
   logic [19:0] timer_ff, nxt_timer;
   logic pend_ff, nxt_pend;
   logic oe_ff, nxt_oe;
   logic so_ff, nxt_so;
   logic [2:0] low_ff, nxt_low;
   logic [7:0] mem [`SWE_MEM_BYTES];
   logic mem_we;
   logic [7:0] mem_wd;
   logic cs_rise, cs_fall, ck_rise;
   logic start_bit, start_cycle, busy, nxt_busy;
   logic [23:0] shifted;
   logic [4:0] cnt_inc, hdr_len, total_len;
   logic [1:0] op, ext;

   // edges of the filtered link pins; the serial clock is sampled, not used as a clock
   assign cs_rise = pins.cs & ~cs_d_ff;
   assign cs_fall = ~pins.cs & cs_d_ff;
   assign ck_rise = pins.sclk & ~ck_d_ff;
   assign shifted = {sreg_ff[22:0], pins.di};
   assign cnt_inc = cnt_ff + 5'h01;
   assign hdr_len = pins.wide ? `SWE_HDR_X16 : `SWE_HDR_X8;
   assign total_len = wide_ff ? `SWE_TOTAL_X16 : `SWE_TOTAL_X8;
   assign op = pins.wide ? shifted[7:6] : shifted[8:7];
   assign ext = pins.wide ? shifted[5:4] : shifted[6:5];
   assign busy = state_ff inside {swe_pkg::SWE_ERASE, swe_pkg::SWE_WAIT, swe_pkg::SWE_PROG};
   assign nxt_busy = nxt_state inside {swe_pkg::SWE_ERASE, swe_pkg::SWE_WAIT, swe_pkg::SWE_PROG};
   // only idle can take a start, so a busy cycle never sees one
   assign start_bit = (state_ff == swe_pkg::SWE_IDLE) && ck_rise && pins.cs && pins.di;
   assign start_cycle = (state_ff == swe_pkg::SWE_ARMED) && cs_fall && en_ff;

   // instruction shifter and programming sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_sreg = sreg_ff;
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      nxt_fill = fill_ff;
      nxt_wide = wide_ff;
      nxt_en = en_ff;
      nxt_idx = idx_ff;
      nxt_first = first_ff;
      nxt_last = last_ff;
      nxt_timer = timer_ff;
      mem_we = 1'b0;
      mem_wd = `SWE_ERASED;
      unique case (state_ff)
         swe_pkg::SWE_IDLE: begin
            if (start_bit) begin
               nxt_state = swe_pkg::SWE_SHIFT;
               nxt_cnt = 5'h00;
               nxt_sreg = 24'h000000;
            end
         end
         swe_pkg::SWE_SHIFT: begin
            if (cs_fall) begin
               nxt_state = swe_pkg::SWE_IDLE;
            end else if (ck_rise) begin
               nxt_sreg = shifted;
               nxt_cnt = cnt_inc;
               if (cnt_inc == hdr_len) begin
                  nxt_wide = pins.wide;
                  nxt_addr = pins.wide ? {1'b0, shifted[5:0]} : shifted[6:0];
                  if (op == `SWE_OP_WRITE) begin
                     nxt_fill = 1'b0;
                  end else if (op == `SWE_OP_EXT && ext == `SWE_EXT_FILL) begin
                     nxt_fill = 1'b1;
                  end else begin
                     // enable and disable act here; other opcodes lie outside this path
                     if (op == `SWE_OP_EXT && ext == `SWE_EXT_ENABLE) begin
                        nxt_en = 1'b1;
                     end
                     if (op == `SWE_OP_EXT && ext == `SWE_EXT_DISABLE) begin
                        nxt_en = 1'b0;
                     end
                     nxt_state = swe_pkg::SWE_SKIP;
                  end
               end else if (cnt_inc == total_len) begin
                  nxt_data = shifted[15:0];
                  nxt_state = swe_pkg::SWE_ARMED;
               end
            end
         end
         swe_pkg::SWE_ARMED: begin
            if (cs_fall) begin
               if (en_ff) begin
                  // the whole cycle runs from here with no serial clock
                  nxt_state = swe_pkg::SWE_ERASE;
                  nxt_first = fill_ff ? 7'h00 : (wide_ff ? {addr_ff[5:0], 1'b0} : addr_ff);
                  nxt_last = fill_ff ? `SWE_LAST_BYTE : (wide_ff ? {addr_ff[5:0], 1'b1} : addr_ff);
                  nxt_idx = nxt_first;
               end else begin
                  nxt_state = swe_pkg::SWE_IDLE;
               end
            end else if (ck_rise) begin
               // a clock after the last bit means select came late; drop it
               nxt_state = swe_pkg::SWE_SKIP;
            end
         end
         swe_pkg::SWE_SKIP: begin
            if (!pins.cs) begin
               nxt_state = swe_pkg::SWE_IDLE;
            end
         end
         swe_pkg::SWE_ERASE: begin
            mem_we = 1'b1;
            if (idx_ff == last_ff) begin
               nxt_state = swe_pkg::SWE_WAIT;
               nxt_timer = fill_ff ? FILL_CYCLES - 20'h00001 : WRITE_CYCLES - 20'h00001;
               nxt_idx = first_ff;
            end else begin
               nxt_idx = idx_ff + 7'h01;
            end
         end
         swe_pkg::SWE_WAIT: begin
            if (timer_ff == 20'h00000) begin
               nxt_state = swe_pkg::SWE_PROG;
            end else begin
               nxt_timer = timer_ff - 20'h00001;
            end
         end
         swe_pkg::SWE_PROG: begin
            mem_we = 1'b1;
            mem_wd = (wide_ff && !idx_ff[0]) ? data_ff[15:8] : data_ff[7:0];
            if (idx_ff == last_ff) begin
               nxt_state = swe_pkg::SWE_IDLE;
            end else begin
               nxt_idx = idx_ff + 7'h01;
            end
         end
         default: begin
            nxt_state = swe_pkg::SWE_IDLE;
         end
      endcase
   end

   // ready/busy output: needs select low for the minimum time, then high
   always_comb begin
      nxt_low = pins.cs ? 3'h0 : ((low_ff >= TCSL_CYCLES) ? low_ff : low_ff + 3'h1);
      nxt_pend = pend_ff;
      if (start_cycle) begin
         nxt_pend = 1'b1;
      end else if (start_bit) begin
         nxt_pend = 1'b0;
      end
      nxt_oe = oe_ff;
      if (cs_fall || start_bit) begin
         nxt_oe = 1'b0;
      end else if (cs_rise && low_ff >= TCSL_CYCLES && pend_ff) begin
         nxt_oe = 1'b1;
      end
      nxt_so = !nxt_busy;
   end

   // state registers; enable starts cleared as after power-up
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_ff <= swe_pkg::SWE_IDLE;
         cs_d_ff <= 1'b0;
         ck_d_ff <= 1'b0;
         cnt_ff <= 5'h00;
         sreg_ff <= 24'h000000;
         addr_ff <= 7'h00;
         data_ff <= 16'h0000;
         fill_ff <= 1'b0;
         wide_ff <= 1'b0;
         en_ff <= 1'b0;
         idx_ff <= 7'h00;
         first_ff <= 7'h00;
         last_ff <= 7'h00;
         timer_ff <= 20'h00000;
         pend_ff <= 1'b0;
         oe_ff <= 1'b0;
         so_ff <= 1'b1;
         low_ff <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         cs_d_ff <= pins.cs;
         ck_d_ff <= pins.sclk;
         cnt_ff <= nxt_cnt;
         sreg_ff <= nxt_sreg;
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         fill_ff <= nxt_fill;
         wide_ff <= nxt_wide;
         en_ff <= nxt_en;
         idx_ff <= nxt_idx;
         first_ff <= nxt_first;
         last_ff <= nxt_last;
         timer_ff <= nxt_timer;
         pend_ff <= nxt_pend;
         oe_ff <= nxt_oe;
         so_ff <= nxt_so;
         low_ff <= nxt_low;
      end
   end

   // array keeps its contents across reset, as nonvolatile storage would
   always_ff @(posedge core_clk) begin
      if (mem_we) begin
         mem[idx_ff] <= mem_wd;
      end
   end

   assign serial_out_pin_o = so_ff;
   assign serial_out_pin_oe = oe_ff;

   a_poll_busy: assert property (
      @(posedge core_clk) disable iff (!rst_n) (serial_out_pin_oe && busy) |-> !serial_out_pin_o)
      else $error("status not low while busy");
   a_poll_ready: assert property (
      @(posedge core_clk) disable iff (!rst_n) (serial_out_pin_oe && !busy) |-> serial_out_pin_o)
      else $error("status not high when ready");
   a_release_fall: assert property (
      @(posedge core_clk) disable iff (!rst_n) cs_fall |=> !serial_out_pin_oe)
      else $error("output not released on select fall");
   a_cycle_start: assert property (
      @(posedge core_clk) disable iff (!rst_n) start_cycle |=> (state_ff == swe_pkg::SWE_ERASE))
      else $error("cycle did not start on select fall");
   a_short_drop: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state_ff == swe_pkg::SWE_SHIFT && cs_fall) |=> (state_ff == swe_pkg::SWE_IDLE) [*2])
      else $error("short instruction not discarded");
   a_disabled_refuse: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state_ff == swe_pkg::SWE_ARMED && cs_fall && !en_ff) |=> !busy)
      else $error("programming while disabled");
   a_timer_load: assert property (
      @(posedge core_clk) disable iff (!rst_n) $rose(state_ff == swe_pkg::SWE_WAIT) |->
      (timer_ff == (fill_ff ? FILL_CYCLES - 20'h00001 : WRITE_CYCLES - 20'h00001)))
      else $error("wrong cycle duration loaded");
   a_fill_max: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(state_ff == swe_pkg::SWE_WAIT) |-> (32'(FILL_CYCLES) <= `SWE_FILL_MAX_NS / `SWE_CLK_NS))
      else $error("fill duration above maximum");
   a_erase_first: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(state_ff == swe_pkg::SWE_WAIT) |-> $past(state_ff == swe_pkg::SWE_ERASE))
      else $error("program without erase");
   a_busy_nostart: assert property (
      @(posedge core_clk) disable iff (!rst_n) busy |=> (state_ff != swe_pkg::SWE_SHIFT))
      else $error("start taken while busy");
   a_fill_sweep: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      (state_ff == swe_pkg::SWE_PROG && fill_ff) |-> (first_ff == 7'h00 && last_ff == `SWE_LAST_BYTE && mem_we))
      else $error("fill does not cover whole array");
endmodule

// >>> testbench/swe_host.sv
// host-side model driving the three-wire programming port
`timescale 1ns/10ps
module swe_host (
   output logic cs,
   output logic sclk,
   output logic di
);
   // link clock stands low between frames
   initial begin
      cs = 1'b0;
      sclk = 1'b0;
      di = 1'b0;
   end

   // shift one frame msb first, start bit included
   task automatic send(input logic [31:0] bits, input int n, input bit extra);
      cs = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         di = bits[i];
         #200 sclk = 1'b1;
         #200 sclk = 1'b0;
      end
      if (extra) begin
         #200 sclk = 1'b1; // stray edge after the last bit
         #200 sclk = 1'b0;
      end
      #100 cs = 1'b0;
      di = ~di; // no stale level left on the line
   endtask

   // select alone, for status polling
   task automatic select(input logic v);
      cs = v;
   endtask
endmodule

// >>> testbench/tb.sv
// self-checking bench for the write and fill-all programming path
`timescale 1ns/10ps
module tb;
   localparam int WR_N = 20;
   localparam int FL_N = 40;
   localparam int LIMIT = 20000;
   localparam logic [31:0] EN16 = 32'h00000130;
   localparam logic [31:0] WR16 = 32'h0145a5c3;
   localparam logic [31:0] EN8 = 32'h00000260;
   localparam logic [31:0] DIS8 = 32'h00000200;
   localparam logic [31:0] FILL8 = 32'h0002203c;
   localparam logic [31:0] WR8 = 32'h0002927e;
   logic core_clk;
   logic rst_n;
   logic wide;
   logic cs;
   logic sclk;
   logic di;
   logic out_o;
   logic out_oe;
   int cyc;
   int errors;
   int total_checks;

   swe_host host (.cs(cs), .sclk(sclk), .di(di));

   swe_core #(.WRITE_CYCLES(20'h14), .FILL_CYCLES(20'h28)) dut (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .dev_select_pin(cs),
      .serial_clk_pin(sclk),
      .serial_in_pin(di),
      .word_width_select(wide),
      .serial_out_pin_o(out_o),
      .serial_out_pin_oe(out_oe)
   );

   // 50 ns core clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // cycle count, also cuts a hang short
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors = errors + 1;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic seen, input logic exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %b seen %b", what, exp, seen);
      end
   endtask

   // settle past the edge before driving or sampling
   task automatic step(input int k);
      repeat (k) @(posedge core_clk);
      #2;
   endtask

   // frame, poll after low cycles, expect status only when hi is nonzero
   task automatic run(input logic [31:0] bits, input int n, input bit extra, input int low,
                      input int lo, input int hi, input bit inject);
      int t0;
      if (n > 0) host.send(bits, n, extra);
      t0 = cyc;
      step(low);
      host.select(1'b1);
      step(6);
      check("status enable", out_oe, hi != 0);
      if (hi != 0) begin
         if (lo > 0) check("busy level", out_o, 1'b0);
         // a start while busy must not restart or extend the cycle
         if (inject) begin
            host.select(1'b0);
            step(6);
            host.send(WR8, 18, 1'b0);
            step(8);
            host.select(1'b1);
            step(6);
         end
         while (out_o !== 1'b1 && cyc - t0 < hi) step(1);
         check("ready in window", (cyc - t0 >= lo) && (cyc - t0 < hi), 1'b1);
         check("ready level", out_o, 1'b1);
      end
      host.select(1'b0);
      step(6);
      check("output released", out_oe, 1'b0);
   endtask

   task automatic t_locked();
      wide = 1'b1;
      run(WR16, 25, 1'b0, 8, 0, 0, 1'b0);
      $display("locked write done");
   endtask

   task automatic t_write_word();
      run(EN16, 9, 1'b0, 8, 0, 0, 1'b0);
      run(WR16, 25, 1'b0, 8, WR_N + 4, WR_N + 24, 1'b0);
      check("word high byte", dut.mem[7'h0a] == 8'ha5, 1'b1);
      check("word low byte", dut.mem[7'h0b] == 8'hc3, 1'b1);
      $display("word write done");
   endtask

   task automatic t_short_frame();
      run(WR16 >> 1, 24, 1'b0, 8, 0, 0, 1'b0);
      $display("short frame done");
   endtask

   task automatic t_stray_clock();
      run(WR16, 25, 1'b1, 8, 0, 0, 1'b0);
      $display("stray clock done");
   endtask

   // select low under 250 ns shows nothing; later poll sees ready
   task automatic t_brief_low();
      run(WR16, 25, 1'b0, 4, 0, 0, 1'b0);
      run(32'h0, 0, 1'b0, 60, 0, 200, 1'b0);
      $display("brief low done");
   endtask

   // x8 fill: erase sweep, timer, program sweep of 128 bytes
   task automatic t_fill();
      wide = 1'b0;
      run(EN8, 10, 1'b0, 8, 0, 0, 1'b0);
      run(FILL8, 18, 1'b0, 8, FL_N + 256, FL_N + 290, 1'b1);
      check("fill first byte", dut.mem[7'h00] == 8'h3c, 1'b1);
      check("fill last byte", dut.mem[7'h7f] == 8'h3c, 1'b1);
      check("fill over start", dut.mem[7'h12] == 8'h3c, 1'b1);
      $display("fill all done");
   endtask

   // reset in mid-run drops enable, so a write must be refused after it
   task automatic t_reset_mid();
      rst_n = 1'b0;
      step(12);
      check("reset enable", out_oe, 1'b0);
      check("reset status", out_o, 1'b1);
      rst_n = 1'b1;
      step(6);
      run(WR8, 18, 1'b0, 8, 0, 0, 1'b0);
      check("write refused", dut.mem[7'h12] == 8'h3c, 1'b1);
      $display("mid reset done");
   endtask

   task automatic t_locked_fill();
      run(DIS8, 10, 1'b0, 8, 0, 0, 1'b0);
      run(FILL8, 18, 1'b0, 8, 0, 0, 1'b0);
      $display("locked fill done");
   endtask

   initial begin
      cyc = 0;
      errors = 0;
      total_checks = 0;
      rst_n = 1'b0;
      wide = 1'b1;
      step(12);
      rst_n = 1'b1;
      step(6);
      t_locked();
      t_write_word();
      t_short_frame();
      t_stray_clock();
      t_brief_low();
      t_fill();
      t_reset_mid();
      t_locked_fill();
      finish_test();
   end
endmodule
